// ===== hw/dsd_pkg.sv
// Shared constants and types for the data-space window and bank decoder
package dsd_pkg;
  localparam int unsigned DATA_AW = 8;
  localparam int unsigned PROG_AW = 12;
  localparam int unsigned WIN_LOW_BITS = 6;
  localparam int unsigned BASE_BITS = 6;
  localparam logic [7:0] ADDR_WIN_LO = 8'h40;
  localparam logic [7:0] ADDR_WIN_HI = 8'h7F;
  localparam logic [7:0] ADDR_BANK_LO = 8'h00;
  localparam logic [7:0] ADDR_BANK_HI = 8'h3F;
  localparam logic [7:0] ADDR_RAM_LO = 8'h84;
  localparam logic [7:0] ADDR_RAM_HI = 8'hBF;
  localparam logic [7:0] ADDR_ROM_WINDOW_BASE = 8'hC9;
  localparam logic [7:0] ADDR_DATA_BANK_SELECT = 8'hE8;
  localparam int unsigned RAM_WORDS = 60;
  localparam int unsigned PAGE_WORDS = 64;
  localparam int unsigned SEL_RAM_PAGE2 = 4;
  localparam int unsigned SEL_EEPROM_PAGE1 = 1;
  localparam int unsigned SEL_EEPROM_PAGE0 = 0;
  localparam logic [7:0] READ_FILL = 8'hFF;
  // Software command port of the core-side end
  localparam logic [1:0] CMD_ADDR = 2'h0;
  localparam logic [1:0] CMD_WDATA = 2'h1;
  localparam logic [1:0] CMD_GO_READ = 2'h2;
  localparam logic [1:0] CMD_GO_WRITE = 2'h3;
  typedef enum logic [1:0] {
    DSD_TGT_NONE,
    DSD_TGT_RAM2,
    DSD_TGT_EE1,
    DSD_TGT_EE0
  } dsd_target_type;
endpackage

// ===== hw/dsd_if.sv
// Data-space bus between the processor core side and the decoder
`timescale 1ns/1ps
`default_nettype none
interface dsd_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport core (output addr, output wdata, output wr, output rd, input rdata);
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

// ===== hw/dsd_page_mem.sv
// One 64-byte data page with synchronous read
`timescale 1ns/1ps
`default_nettype none
module dsd_page_mem #(
  parameter int unsigned WORDS = 64,
  parameter int unsigned AW = 6
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [WORDS];
  // Storage holds no reset, like real RAM
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// ===== hw/dsd_decoder.sv
// Device end: data-space decode, read-only window and page banking
// How it works
// RULE1: Reads 40h-7Fh return program memory bytes
// RULE2: Program address is base then six offset bits
// RULE3: Window reaches program bytes 000h to FFFh
// RULE4: Window base at C9h, write only
// RULE5: Window base not cleared by reset
// RULE6: Only base bits 5..0 kept
// RULE7: Bank select at E8h, write only
// RULE8: Bit 4 maps RAM page 2
// RULE9: Bits 1 and 0 map EEPROM pages
// RULE10: Pages appear at 00h-3Fh
// RULE11: Bank select not cleared at initialisation
// RULE12: Calls and interrupts keep bank select
// RULE13: Software sets one page bit only
// RULE14: Software keeps RAM image of registers
// RULE15: No page change during EEPROM parallel write
// RULE16: Sixty bytes of fixed RAM present
// RULE17: Unmapped or write-only reads give fill value
`timescale 1ns/1ps
`default_nettype none
module dsd_decoder
  import dsd_pkg::*;
#(
  parameter bit HAS_EE_PAGE1 = 1'b1,
  parameter bit HAS_EE_PAGE0 = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  dsd_if.dev bus,
  output logic [dsd_pkg::PROG_AW-1:0] o_prog_addr,
  input wire logic [7:0] i_prog_data,
  output logic o_ee_parallel_hazard,
  output logic [7:0] o_bank_select_state
);
  import dsd_pkg::*;

  logic [BASE_BITS-1:0] base_reg, base_next;
  logic [7:0] bank_reg, bank_next;
  logic [2:0] src_reg, src_next;
  logic [WIN_LOW_BITS-1:0] off;
  logic in_win, in_bank, in_ram;
  logic [7:0] ram_q, ram2_q, ee0_q, ee1_q;
  logic [7:0] rdata;
  logic [7:0] ram_idx;

  assign off = bus.addr[WIN_LOW_BITS-1:0];
  assign in_win = (bus.addr >= ADDR_WIN_LO) && (bus.addr <= ADDR_WIN_HI); // see RULE1
  assign in_bank = (bus.addr <= ADDR_BANK_HI); // see RULE10
  assign in_ram = (bus.addr >= ADDR_RAM_LO) && (bus.addr <= ADDR_RAM_HI); // see RULE16
  assign ram_idx = bus.addr - ADDR_RAM_LO;

  // Registers load only on their own write; nothing else touches them
  always_comb begin
    base_next = base_reg;
    bank_next = bank_reg;
    if (bus.wr && bus.addr == ADDR_ROM_WINDOW_BASE) begin
      base_next = bus.wdata[BASE_BITS-1:0]; // see RULE4, RULE6
    end
    if (bus.wr && bus.addr == ADDR_DATA_BANK_SELECT) begin
      bank_next = bus.wdata; // see RULE7, RULE12
    end
  end

  // No reset branch: contents are undefined until software writes them
  always_ff @(posedge i_clk) begin
    base_reg <= base_next; // see RULE5
    bank_reg <= bank_next; // see RULE11
  end

  // Window address is combinational so program memory answers next cycle
  assign o_prog_addr = {base_reg, off}; // see RULE2, RULE3

  // Source of the read data for the following cycle
  always_comb begin
    src_next = 3'h0;
    if (bus.rd) begin
      if (in_win) begin
        src_next = 3'h1;
      end else if (in_ram) begin
        src_next = 3'h2;
      end else if (in_bank) begin
        // With several bits set the first match wins; software must not
        if (bank_reg[SEL_RAM_PAGE2]) begin
          src_next = 3'h3; // see RULE8
        end else if (HAS_EE_PAGE1 && bank_reg[SEL_EEPROM_PAGE1]) begin
          src_next = 3'h4; // see RULE9
        end else if (HAS_EE_PAGE0 && bank_reg[SEL_EEPROM_PAGE0]) begin
          src_next = 3'h5; // see RULE9
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_reg <= 3'h0;
    end else begin
      src_reg <= src_next;
    end
  end

  dsd_page_mem #(.WORDS(RAM_WORDS), .AW(6)) u_fixed_ram (
    .i_clk(i_clk),
    .i_we(bus.wr && in_ram),
    .i_addr(ram_idx[5:0]),
    .i_wdata(bus.wdata),
    .o_rdata(ram_q)
  );

  // Writes to the banked region go to every selected page
  dsd_page_mem #(.WORDS(PAGE_WORDS), .AW(6)) u_ram_page2 (
    .i_clk(i_clk),
    .i_we(bus.wr && in_bank && bank_reg[SEL_RAM_PAGE2]), // see RULE8, RULE10
    .i_addr(off),
    .i_wdata(bus.wdata),
    .o_rdata(ram2_q)
  );

  dsd_page_mem #(.WORDS(PAGE_WORDS), .AW(6)) u_ee_page1 (
    .i_clk(i_clk),
    .i_we(bus.wr && in_bank && HAS_EE_PAGE1 && bank_reg[SEL_EEPROM_PAGE1]), // see RULE9
    .i_addr(off),
    .i_wdata(bus.wdata),
    .o_rdata(ee1_q)
  );

  dsd_page_mem #(.WORDS(PAGE_WORDS), .AW(6)) u_ee_page0 (
    .i_clk(i_clk),
    .i_we(bus.wr && in_bank && HAS_EE_PAGE0 && bank_reg[SEL_EEPROM_PAGE0]), // see RULE9
    .i_addr(off),
    .i_wdata(bus.wdata),
    .o_rdata(ee0_q)
  );

  // Write-only registers and unmapped reads return the fill, no side effect
  always_comb begin
    case (src_reg)
      3'h1: rdata = i_prog_data; // see RULE1
      3'h2: rdata = ram_q;
      3'h3: rdata = ram2_q;
      3'h4: rdata = ee1_q;
      3'h5: rdata = ee0_q;
      default: rdata = READ_FILL; // see RULE17
    endcase
  end
  assign bus.rdata = rdata;

  // Flags more than one page bit set, which software must avoid
  assign o_ee_parallel_hazard = ($countones(bank_reg & 8'h13) > 1); // see RULE13
  assign o_bank_select_state = bank_reg;
endmodule
`default_nettype wire

// ===== hw/dsd_core_port.sv
// Core end: turns a software command port into data-space accesses
`timescale 1ns/1ps
`default_nettype none
module dsd_core_port
  import dsd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  dsd_if.core bus,
  input wire logic [1:0] i_sw_addr,
  input wire logic [7:0] i_sw_wdata,
  input wire logic i_sw_wr,
  input wire logic i_sw_rd,
  output logic [7:0] o_sw_rdata
);
  import dsd_pkg::*;

  typedef enum {DSD_IDLE, DSD_WAIT} dsd_state_type;
  dsd_state_type state_reg, state_next;
  logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next, result_reg, result_next;
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic [7:0] sw_rdata_reg, sw_rdata_next;

  // Core keeps its last bus address, write data and read result for readback, no image of the write-only registers; see RULE14
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    result_next = result_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    sw_rdata_next = sw_rdata_reg;
    if (i_sw_wr) begin
      case (i_sw_addr)
        CMD_ADDR: addr_next = i_sw_wdata;
        CMD_WDATA: wdata_next = i_sw_wdata;
        CMD_GO_READ: rd_next = 1'b1;
        CMD_GO_WRITE: wr_next = 1'b1;
        default: ;
      endcase
    end
    case (state_reg)
      DSD_IDLE: begin
        if (rd_reg) begin
          state_next = DSD_WAIT;
        end
      end
      DSD_WAIT: begin
        result_next = bus.rdata;
        state_next = DSD_IDLE;
      end
      default: state_next = DSD_IDLE;
    endcase
    if (i_sw_rd) begin
      case (i_sw_addr)
        CMD_ADDR: sw_rdata_next = addr_reg;
        CMD_WDATA: sw_rdata_next = wdata_reg;
        default: sw_rdata_next = result_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= DSD_IDLE;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      result_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      sw_rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      result_reg <= result_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      sw_rdata_reg <= sw_rdata_next;
    end
  end

  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign bus.wr = wr_reg;
  assign bus.rd = rd_reg;
  assign o_sw_rdata = sw_rdata_reg;
endmodule
`default_nettype wire

// ===== test/dsd_properties.sv
// Concurrent checks on the data-space bus joining the two ends
`timescale 1ns/1ps
`default_nettype none
module dsd_properties
  import dsd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [dsd_pkg::PROG_AW-1:0] o_prog_addr,
  input wire logic [7:0] i_prog_data,
  input wire logic [7:0] o_bank_select_state
);
  logic [5:0] base_reg;
  logic [5:0] base_next;
  logic [1:0] ok_reg;
  logic [1:0] ok_next;
  always_comb begin
    base_next = base_reg;
    ok_next = ok_reg;
    if (wr && addr == ADDR_ROM_WINDOW_BASE) begin
      base_next = wdata[5:0];
      ok_next[0] = 1'b1;
    end
    if (wr && addr == ADDR_DATA_BANK_SELECT) begin
      ok_next[1] = 1'b1;
    end
  end
  // Valid flags forget on reset, since the real registers hold unknown data
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ok_reg <= 2'h0;
    end else begin
      ok_reg <= ok_next;
    end
  end
  always_ff @(posedge i_clk) begin
    base_reg <= base_next;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence win_rd_s;
    rd && addr[7:6] == 2'b01;
  endsequence
  sequence wo_rd_s;
    rd && (addr == ADDR_ROM_WINDOW_BASE || addr == ADDR_DATA_BANK_SELECT);
  endsequence
  sequence bank_wr_s;
    wr && addr == ADDR_DATA_BANK_SELECT;
  endsequence
  win_addr_a: assert property (win_rd_s |-> !ok_reg[0] || o_prog_addr == {base_reg, addr[5:0]})
    else $error("window program address wrong");
  win_data_a: assert property (win_rd_s |=> rdata == i_prog_data)
    else $error("window read data wrong");
  wo_fill_a: assert property (wo_rd_s |=> rdata == READ_FILL)
    else $error("write-only register read not filled");
  idle_fill_a: assert property (!rd |=> rdata == READ_FILL)
    else $error("read data outside answer cycle");
  bank_load_a: assert property (bank_wr_s |=> o_bank_select_state == $past(wdata))
    else $error("bank select not loaded");
  bank_keep_a: assert property (ok_reg[1] && !wr |=> $stable(o_bank_select_state))
    else $error("bank select changed without write");
  bank_none_a: assert property (rd && addr <= ADDR_BANK_HI && ok_reg[1]
      && o_bank_select_state[4] == 1'b0 && o_bank_select_state[1:0] == 2'h0
      |=> rdata == READ_FILL)
    else $error("unselected bank read not filled");
  rw_excl_a: assert property (!(rd && wr))
    else $error("read and write strobes together");
endmodule
`default_nettype wire

// ===== test/data_space_window_bank_decode_tb_top.sv
// Testbench driving the core end and checking the decoder end
`timescale 1ns/1ps
`default_nettype none
module data_space_window_bank_decode_tb_top;
  import dsd_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [1:0] sw_addr = 2'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic [11:0] prog_addr;
  logic [7:0] prog_data = 8'h00;
  logic hazard;
  logic [7:0] bank_state;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 i_clk = ~i_clk;
  dsd_if bus();
  dsd_core_port i_dsd_core_port(.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
    .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd),
    .o_sw_rdata(sw_rdata));
  dsd_decoder i_dsd_decoder(.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
    .o_prog_addr(prog_addr), .i_prog_data(prog_data), .o_ee_parallel_hazard(hazard),
    .o_bank_select_state(bank_state));
  dsd_properties i_dsd_properties(.i_clk(i_clk), .i_resetn(i_resetn), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .o_prog_addr(prog_addr), .i_prog_data(prog_data), .o_bank_select_state(bank_state));
  // Program memory answers one cycle after the address
  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'hA};
  endfunction
  always @(posedge i_clk) prog_data <= rom(prog_addr);
  task automatic results;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic sw(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge i_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    sw(CMD_ADDR, a);
    sw(CMD_WDATA, d);
    sw(CMD_GO_WRITE, 8'h00);
    // Bus write pulse lands one edge after the command is taken
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    sw(CMD_ADDR, a);
    sw(CMD_GO_READ, 8'h00);
    repeat (3) @(posedge i_clk);
    sw_addr <= CMD_GO_READ;
    sw_rd <= 1'b1;
    @(posedge i_clk);
    sw_rd <= 1'b0;
    @(negedge i_clk);
    chk(n, e, sw_rdata);
  endtask
  task automatic t_window;
    bw(ADDR_ROM_WINDOW_BASE, 8'h28);
    rdc("win", 8'h59, rom(12'hA19));
    bw(ADDR_ROM_WINDOW_BASE, 8'hFF);
    rdc("win_top", 8'h7F, rom(12'hFFF));
    bw(ADDR_ROM_WINDOW_BASE, 8'hC0);
    rdc("win_bot", 8'h40, rom(12'h000));
    rdc("base_rd", ADDR_ROM_WINDOW_BASE, READ_FILL);
    rdc("bank_rd", ADDR_DATA_BANK_SELECT, READ_FILL);
    rdc("gap_rd", 8'hC3, READ_FILL);
  endtask
  task automatic t_banks;
    logic [7:0] pg [3];
    pg = '{8'h10, 8'h02, 8'h01};
    // EEPROM parallel write never enabled, so page changes stay legal
    foreach (pg[i]) begin
      bw(ADDR_DATA_BANK_SELECT, pg[i]);
      chk("bank", pg[i], bank_state);
      bw(8'h00, pg[i] ^ 8'h5A);
      bw(8'h3F, pg[i] ^ 8'hA5);
    end
    foreach (pg[i]) begin
      bw(ADDR_DATA_BANK_SELECT, pg[i]);
      rdc("page_lo", 8'h00, pg[i] ^ 8'h5A);
      rdc("page_hi", 8'h3F, pg[i] ^ 8'hA5);
    end
    bw(ADDR_DATA_BANK_SELECT, 8'h00);
    rdc("no_page", 8'h3F, READ_FILL);
    bw(ADDR_DATA_BANK_SELECT, 8'h11);
    chk("hazard", 8'h01, {7'h00, hazard});
  endtask
  task automatic t_ram_reset;
    bw(ADDR_DATA_BANK_SELECT, 8'h10);
    bw(8'h84, 8'hA5);
    bw(8'hBF, 8'h5A);
    rdc("ram_lo", 8'h84, 8'hA5);
    rdc("ram_hi", 8'hBF, 8'h5A);
    chk("bank_kept", 8'h10, bank_state);
    // Mid-run reset must leave both mapping registers alone
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    chk("bank_reset", 8'h10, bank_state);
    rdc("win_reset", 8'h41, rom(12'h001));
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_window();
    t_banks();
    t_ram_reset();
    results();
  end
endmodule
`default_nettype wire
